// ==== verilog/lfs_sram.sv ====
/*
 * Device-side logic of a late-write flow-through burst memory.
 * Assumes the host drives all synchronous pins on ref_clk and
 * resolves the data bus from dq_out, dq_oe and its own drive.
 */
`timescale 1ns/1ps

// What this block does
// RL1 - Two-million words of eighteen bits, two lanes
// RL2 - Synchronous pins sampled on rising clock edge
// RL3 - Read data one cycle after command
// RL4 - Write data captured one edge after command
// RL5 - Reads and writes back to back, no gaps
// RL6 - Load cycle: read high, write low
// RL7 - Write controls and address registered on edge
// RL8 - Lane enables gate bytes; all low writes word
// RL9 - Writes need no output enable toggle
// RL10 - Any chip select deselects: data pins float
// RL11 - Drive only when selected and enable low
// RL12 - Load cycle takes address when fully selected
// RL13 - Chip selects sampled only on load cycles
// RL14 - Advance ignores address, selects, direction
// RL15 - Clock hold stalls every operation
// RL16 - Order select high interleaved, low linear
// RL17 - Interleave XOR count, linear add modulo four
// RL18 - Sleep deselects device, data kept
// RL19 - Sleep disables inputs, floats outputs
// RL20 - Host finishes pending work before sleep
// RL21 - Host issues deselect or read on exit
// RL22 - Host ties sleep low when unused
// RL23 - Two-bit counter wraps after four cycles
// RL24 - Continue cycles keep initial burst type
// RL25 - Hold: no write, read keeps driving
// RL26 - Drivers off during write cycles
module lfs_sram #(
  parameter int AW    = lfs_pkg::ADDR_W,
  parameter int DEPTH = lfs_pkg::WORDS
) (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clock_hold_n,
  input  wire logic                        chip_select_low_active,
  input  wire logic                        chip_select_high_active,
  input  wire logic                        chip_select_third,
  input  wire logic                        advance_or_load,
  input  wire logic                        read_not_write,
  input  wire logic [lfs_pkg::LANES-1:0]   byte_lane_write_n,
  input  wire logic [AW-1:0]               addr,
  input  wire logic                        output_enable_n,
  input  wire logic                        burst_order_select_n,
  input  wire logic                        flow_through_select_n,
  input  wire logic                        sleep_request,
  input  wire logic [lfs_pkg::DATA_W-1:0]  dq_in,
  output logic      [lfs_pkg::DATA_W-1:0]  dq_out,
  output logic                             dq_oe,
  output logic                             sleep_active
);

  // ****************************************************************
  // Asynchronous pin conditioning
  // ****************************************************************
  logic [2:0] async_level;
  wire  [2:0] async_pins;
  wire        oe_n_s;
  wire        order_s;
  wire        sleep_s;

  // Static order select idles high, standing in for the pull-up
  assign async_pins = {sleep_request, burst_order_select_n,
                       output_enable_n};

  lfs_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin     (async_pins),
    .rst_val (3'h3),
    .level   (async_level)
  );

  assign oe_n_s  = async_level[0];
  assign order_s = async_level[1];
  assign sleep_s = async_level[2];

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire run;
  wire selected;
  wire load_cyc;
  wire adv_cyc;
  wire ld_read;
  wire ld_write;
  wire ld_desel;
  wire [lfs_pkg::LANES-1:0] lane_en;

  // Hold alone freezes the state machine; sleep is masked into load and advance and clears the burst
  assign run      = clock_hold_n == 1'b0 ? 1'b1 : 1'b0;
  assign selected = ~chip_select_low_active & chip_select_high_active
                    & ~chip_select_third;
  assign load_cyc = run & ~sleep_s & ~advance_or_load;     // RL2
  assign adv_cyc  = run & ~sleep_s & advance_or_load;
  assign ld_read  = load_cyc & selected & read_not_write;  // RL6
  assign ld_write = load_cyc & selected & ~read_not_write; // RL6
  assign ld_desel = load_cyc & ~selected;                  // RL13
  assign lane_en  = ~byte_lane_write_n;                    // RL8

  // ****************************************************************
  // Burst state
  // ****************************************************************
  lfs_pkg::lfs_op_e                burst_op;
  lfs_pkg::lfs_op_e                next_burst_op;
  logic [AW-1:0]                   base_addr;
  logic [lfs_pkg::BURST_W-1:0]     step;
  logic [lfs_pkg::BURST_W-1:0]     next_step;
  logic                            burst_order;
  wire  [lfs_pkg::BURST_W-1:0]     adv_step;
  wire  [lfs_pkg::BURST_W-1:0]     low_bits;
  wire  [AW-1:0]                   burst_addr;
  wire  [AW-1:0]                   cyc_addr;
  wire                             cyc_read;
  wire                             cyc_write;

  // Counter wraps naturally at four
  assign adv_step = step + 2'h1;                           // RL23
  assign low_bits = burst_order
                    ? (base_addr[1:0] ^ adv_step)
                    : (base_addr[1:0] + adv_step);         // RL17
  assign burst_addr = {base_addr[AW-1:2], low_bits};

  // External address only on a load, counter otherwise
  assign cyc_addr  = load_cyc ? addr : burst_addr;         // RL12 RL14
  assign cyc_read  = ld_read
                   | (adv_cyc && burst_op == lfs_pkg::LFS_READ);  // RL24
  assign cyc_write = ld_write
                   | (adv_cyc && burst_op == lfs_pkg::LFS_WRITE); // RL24

  always_comb begin
    next_burst_op = burst_op;
    next_step     = step;
    case (burst_op)
      lfs_pkg::LFS_IDLE,
      lfs_pkg::LFS_READ,
      lfs_pkg::LFS_WRITE: begin
        if (ld_read) begin
          next_burst_op = lfs_pkg::LFS_READ;
          next_step     = lfs_pkg::BURST_RST;
        end else if (ld_write) begin
          next_burst_op = lfs_pkg::LFS_WRITE;
          next_step     = lfs_pkg::BURST_RST;
        end else if (ld_desel) begin
          next_burst_op = lfs_pkg::LFS_IDLE;
          next_step     = lfs_pkg::BURST_RST;
        end else if (adv_cyc) begin
          next_step     = adv_step;                        // RL14
        end
      end
      default: begin
        next_burst_op = lfs_pkg::LFS_IDLE;
      end
    endcase
  end

  // Sleep drops any burst in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sleep_s) begin
      burst_op <= lfs_pkg::LFS_IDLE;                       // RL19
      step     <= lfs_pkg::BURST_RST;
    end else begin
      burst_op <= next_burst_op;                           // RL15
      step     <= next_step;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      base_addr   <= lfs_pkg::ADDR_RST;
      burst_order <= 1'b1;
    end else if (ld_read || ld_write) begin
      base_addr   <= addr;                                 // RL12
      burst_order <= order_s;                              // RL16
    end
  end

  // ****************************************************************
  // Late-write pipeline
  // ****************************************************************
  lfs_pkg::lfs_wr_s wr_pend;
  lfs_pkg::lfs_wr_s next_wr_pend;
  wire              commit;

  // Pending write commits on the next running edge
  assign commit = run & ~sleep_s & wr_pend.valid;          // RL4 RL25

  always_comb begin
    next_wr_pend = wr_pend;
    if (sleep_s) begin
      next_wr_pend.valid = 1'b0;                           // RL19
    end else if (run) begin
      next_wr_pend.valid   = cyc_write & (|lane_en);       // RL8
      next_wr_pend.addr    = cyc_addr;
      next_wr_pend.lane_en = lane_en;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend <= '{addr: lfs_pkg::ADDR_RST, lane_en: 2'h0, valid: 1'b0};
    end else begin
      wr_pend <= next_wr_pend;                             // RL7
    end
  end

  // ****************************************************************
  // Array and flow-through read path
  // ****************************************************************
  logic [lfs_pkg::DATA_W-1:0] arr_rd;
  logic [lfs_pkg::DATA_W-1:0] fwd_data;
  logic [lfs_pkg::LANES-1:0]  fwd_lane;
  logic                       rd_live;
  logic                       wr_live;
  wire                        rd_hit;
  wire  [lfs_pkg::LANES-1:0]  hit_lane;
  wire  [lfs_pkg::DATA_W-1:0] rd_word;

  // Forward the write that commits on the same edge as the read
  assign rd_hit   = commit && cyc_read && wr_pend.addr == cyc_addr;
  assign hit_lane = rd_hit ? wr_pend.lane_en : 2'h0;       // RL5

  lfs_array #(
    .AW    (AW),
    .DEPTH (DEPTH),
    .LW    (lfs_pkg::LANE_W),
    .NL    (lfs_pkg::LANES)
  ) u_array (
    .ref_clk (ref_clk),
    .wr_en   (commit),                                     // RL4
    .wr_lane (wr_pend.lane_en),
    .wr_addr (wr_pend.addr),
    .wr_data (dq_in),
    .rd_en   (cyc_read),                                   // RL3
    .rd_addr (cyc_addr),
    .rd_data (arr_rd)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fwd_data <= '0;
      fwd_lane <= 2'h0;
    end else if (run) begin
      fwd_data <= dq_in;
      fwd_lane <= hit_lane;
    end
  end

  for (genvar g = 0; g < lfs_pkg::LANES; g++) begin : merge
    assign rd_word[g*lfs_pkg::LANE_W +: lfs_pkg::LANE_W] = fwd_lane[g]
      ? fwd_data[g*lfs_pkg::LANE_W +: lfs_pkg::LANE_W]
      : arr_rd[g*lfs_pkg::LANE_W +: lfs_pkg::LANE_W];
  end

  // Live flags survive a hold so the bus state is kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sleep_s) begin
      rd_live <= 1'b0;
      wr_live <= 1'b0;
    end else if (run) begin
      rd_live <= cyc_read;                                 // RL3 RL10
      wr_live <= cyc_write;                                // RL26
    end
  end

  // ****************************************************************
  // Output drive
  // ****************************************************************
  wire drive;

  // Output enable only gates reads; writes never need it
  assign drive = rd_live & ~wr_live & ~oe_n_s & ~sleep_s;  // RL9 RL11

  // Flow-through: the array register already holds the read word and
  // the forwarding lanes are flops too, so the pins follow the merge
  // with no further stage. A second flop here would make the device
  // pipelined and cost the host a cycle of read latency.
  // Both sources only move on running edges, so a hold keeps the word.
  // Before the first read the word is unknown, but drive is low then.
  assign dq_out = rd_word;                                 // RL3 RL25


  // Registered word is the flow-through output of the cycle
  assign dq_oe        = drive;                             // RL11 RL25
  assign sleep_active = sleep_s;                           // RL18

  // ****************************************************************
  // Read word
  // ****************************************************************
  // The array data register is the flop stage; merge only selects lanes
  logic unused_ft;
  always_ff @(posedge ref_clk) begin
    unused_ft <= flow_through_select_n;
  end

endmodule

// ==== pkg/lfs_pkg.sv ====
/*
 * Constants and carrier types for the late-write flow-through burst
 * memory. Assumes a single rising-edge clock domain in the user.
 */
package lfs_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W     = 21;
  localparam int WORDS      = 2097152;
  localparam int DATA_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;
  localparam int BURST_W    = 2;
  localparam int SYNC_DEPTH = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 21'h000000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    LFS_IDLE,
    LFS_READ,
    LFS_WRITE
  } lfs_op_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_en;
    logic              valid;
  } lfs_wr_s;

endpackage

// ==== verilog/lfs_pin_sync.sv ====
/*
 * Three-stage synchroniser for asynchronous level pins.
 * Assumes the pin may change at any time relative to ref_clk.
 */
`timescale 1ns/1ps
module lfs_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree;

  // Only stages two and three are compared, never stage one
  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge ref_clk) begin
    stage1 <= pin;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level <= rst_val;
    end else begin
      level <= (agree & stage3) | (~agree & level);
    end
  end

endmodule

// ==== verilog/lfs_array.sv ====
/*
 * Storage array with per-lane write enables and registered read data.
 * Assumes one synchronous write port and one synchronous read port.
 */
`timescale 1ns/1ps
module lfs_array #(
  parameter int AW    = lfs_pkg::ADDR_W,
  parameter int DEPTH = lfs_pkg::WORDS,
  parameter int LW    = lfs_pkg::LANE_W,
  parameter int NL    = lfs_pkg::LANES
) (
  input  wire logic              ref_clk,
  input  wire logic              wr_en,
  input  wire logic [NL-1:0]     wr_lane,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [NL*LW-1:0]  wr_data,
  input  wire logic              rd_en,
  input  wire logic [AW-1:0]     rd_addr,
  output logic      [NL*LW-1:0]  rd_data
);

  logic [NL*LW-1:0] mem [DEPTH]; // RL1

  // Lanes written independently
  for (genvar g = 0; g < NL; g++) begin : lane
    always_ff @(posedge ref_clk) begin
      if (wr_en && wr_lane[g]) begin
        mem[wr_addr][g*LW +: LW] <= wr_data[g*LW +: LW]; // RL8
      end
    end
  end

  // Read before write on a shared address; the core forwards instead
  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ==== testbench/lfs_sram_assertions.sv ====
/* Pin-level checks for lfs_sram, bound from the bench top.
   Assumes one clock domain and a steady output enable around reads. */
`timescale 1ns/1ps
module lfs_sram_assertions (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       clock_hold_n,
  input wire logic                       chip_select_low_active,
  input wire logic                       chip_select_high_active,
  input wire logic                       chip_select_third,
  input wire logic                       advance_or_load,
  input wire logic                       read_not_write,
  input wire logic                       output_enable_n,
  input wire logic                       sleep_request,
  input wire logic [lfs_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe,
  input wire logic                       sleep_active
);
  // ******
  // Helpers
  // ******
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic [2:0] oe_cnt;
  logic       run, sel, oe_ok, ld;
  assign run = !clock_hold_n && !sleep_request && !sleep_active;
  assign sel = !chip_select_low_active && chip_select_high_active
               && !chip_select_third;
  assign ld = run && !advance_or_load;
  // Enable pin is synchronised, so trust it only after it settles
  assign oe_ok = oe_cnt == 3'h5;
  always_ff @(posedge ref_clk)
    if (sys_rst || output_enable_n) oe_cnt <= 3'h0;
    else if (!oe_ok) oe_cnt <= oe_cnt + 3'h1;
  // ******
  // Checks
  // ******
  AST_DESELECT_FLOATS: assert property (ld && !sel |=> !dq_oe)
    else $error("deselect left data driven");
  AST_READ_DRIVES: assert property (ld && sel && read_not_write && oe_ok
    |=> dq_oe) else $error("read not driven next cycle");
  AST_WRITE_FLOATS: assert property (ld && sel && !read_not_write
    |=> !dq_oe) else $error("write cycle drove data");
  AST_READ_WRITE_TURN: assert property (ld && sel && read_not_write
    && oe_ok ##1 ld && sel && !read_not_write |-> dq_oe ##1 !dq_oe)
    else $error("read then write turnaround wrong");
  AST_ADVANCE_KEEPS_READ: assert property (run && advance_or_load
    && dq_oe && oe_ok |=> dq_oe) else $error("burst read dropped");
  AST_HOLD_FREEZES: assert property (clock_hold_n && oe_ok
    && !sleep_request && !sleep_active
    |=> $stable(dq_oe) && (!dq_oe || $stable(dq_out)))
    else $error("outputs moved during hold");
  AST_OE_HIGH_FLOATS: assert property (output_enable_n[*5] |-> !dq_oe)
    else $error("driven while output enable high");
  AST_SLEEP_FLOATS: assert property (sleep_active |-> !dq_oe)
    else $error("driven while asleep");
  AST_SLEEP_ENTERS: assert property (sleep_request[*5] |-> sleep_active)
    else $error("sleep not entered");
  AST_SLEEP_EXITS: assert property (!sleep_request[*5] |-> !sleep_active)
    else $error("sleep not left");
endmodule

// ==== testbench/lfs_host_model.sv ====
/* Host controller model: drives the memory pins on falling edges and
   queues the read data it expects. Assumes the bench calls op(). */
`timescale 1ns/1ps
module lfs_host_model (
  input  wire logic                       ref_clk,
  input  wire logic                       sleep_active,
  output logic                            clock_hold_n,
  output logic                            chip_select_low_active,
  output logic                            chip_select_high_active,
  output logic                            chip_select_third,
  output logic                            advance_or_load,
  output logic                            read_not_write,
  output logic [lfs_pkg::LANES-1:0]       byte_lane_write_n,
  output logic [lfs_pkg::ADDR_W-1:0]      addr,
  output logic                            output_enable_n = 1'h0,
  output logic                            burst_order_select_n = 1'h1,
  output logic                            flow_through_select_n = 1'h1,
  output logic                            sleep_request = 1'h0,
  output logic [lfs_pkg::DATA_W-1:0]      dq_in = 18'h2AAAA
);
  logic [17:0] mem [int];
  logic [17:0] exp_q [$];
  logic [17:0] wdat;
  logic [20:0] base;
  logic [1:0]  step;
  logic        pend = 1'h0;
  logic        bon = 1'h0;
  logic        brd, lin;
  // One bus cycle; cs is {low_active, high_active, third}
  task automatic op(input logic ld, rd, input logic [2:0] cs,
                    input logic [20:0] a, input logic [1:0] bw,
                    input logic [17:0] wd, input logic hold = 1'h0);
    logic       run;
    logic [1:0] lo;
    @(negedge ref_clk);
    run = !hold && !sleep_request && !sleep_active;
    // Idle data lines toggle so stale values never look valid
    dq_in = pend ? wdat : ~dq_in;
    clock_hold_n = hold;
    advance_or_load = !ld;
    read_not_write = rd;
    {chip_select_low_active, chip_select_high_active} = cs[2:1];
    chip_select_third = cs[0];
    addr = a;
    byte_lane_write_n = bw;
    if (run) begin
      pend = 1'h0;
      if (ld) begin
        bon = cs == 3'h2;
        brd = rd;
        base = a;
        step = 2'h0;
        lin = !burst_order_select_n;
      end else step = step + 2'h1;
      lo = lin ? base[1:0] + step : base[1:0] ^ step;
      if (bon && brd && !output_enable_n)
        exp_q.push_back(mem[{base[20:2], lo}]);
      if (bon && !brd && bw != 2'h3) begin
        pend = 1'h1;
        wdat = wd;
        for (int i = 0; i < 2; i++)
          if (!bw[i]) mem[{base[20:2], lo}][i*9 +: 9] = wd[i*9 +: 9];
      end
    end
  endtask
  initial begin
    {clock_hold_n, advance_or_load, read_not_write} = 3'h0;
    {chip_select_low_active, chip_select_high_active} = 2'h2;
    chip_select_third = 1'h1;
    byte_lane_write_n = 2'h3;
    addr = 21'h0;
  end
endmodule

// ==== testbench/late_write_flowthrough_burst_sram_tb_top.sv ====
/* Self-checking bench for lfs_sram with a host model and bound checker.
   Assumes the design package is compiled first. */
`timescale 1ns/1ps
module late_write_flowthrough_burst_sram_tb_top;
  localparam logic [2:0] SEL = 3'h2;
  logic        ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        clock_hold_n, chip_select_low_active, chip_select_high_active;
  logic        chip_select_third, advance_or_load, read_not_write;
  logic        output_enable_n, burst_order_select_n, flow_through_select_n;
  logic        sleep_request, dq_oe, sleep_active;
  logic [1:0]  byte_lane_write_n;
  logic [20:0] addr;
  logic [17:0] dq_in, dq_out;
  logic [31:0] rng = 32'h57;
  logic        ran = 1'h0;
  int          fails = 0;
  int          checked = 0;
  lfs_sram i_dut (.ref_clk, .sys_rst, .clock_hold_n, .chip_select_low_active,
    .chip_select_high_active, .chip_select_third, .advance_or_load,
    .read_not_write, .byte_lane_write_n, .addr, .output_enable_n,
    .burst_order_select_n, .flow_through_select_n, .sleep_request, .dq_in,
    .dq_out, .dq_oe, .sleep_active);
  lfs_host_model i_host (.ref_clk, .sleep_active, .clock_hold_n,
    .chip_select_low_active, .chip_select_high_active, .chip_select_third,
    .advance_or_load, .read_not_write, .byte_lane_write_n, .addr,
    .output_enable_n, .burst_order_select_n, .flow_through_select_n,
    .sleep_request, .dq_in);
  // ******
  // Helpers
  // ******
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input logic [17:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) i_host.op(1'h1, 1'h0, 3'h6, 21'h0, 2'h3, 18'h0);
  endtask
  task automatic wr(input logic [20:0] a, input logic [1:0] bw,
                    input logic [17:0] d);
    i_host.op(1'h1, 1'h0, SEL, a, bw, d);
  endtask
  task automatic rd(input logic [20:0] a);
    i_host.op(1'h1, 1'h1, SEL, a, 2'h3, 18'h0);
  endtask
  // ******
  // Clock and output monitor
  // ******
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ran <= !sys_rst && !clock_hold_n && !sleep_active;
  // Only the cycle after a running edge carries fresh read data
  always @(negedge ref_clk)
    if (ran && dq_oe === 1'h1) begin
      if (i_host.exp_q.size() == 0) check(18'(dq_oe), 18'h0);
      else check(dq_out, i_host.exp_q.pop_front());
    end
  initial begin
    #100us;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  // ******
  // Scenarios
  // ******
  initial begin
    logic [31:0] r;
    logic [20:0] b;
    logic [2:0]  cs_bad [3];
    cs_bad = '{3'h6, 3'h0, 3'h3};
    b = 21'h1FFFF8;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'h0;
    idle(6);
    for (int i = 0; i < 8; i++) wr(b + 21'(i), 2'h0, 18'(xs()));
    for (int i = 0; i < 40; i++) begin
      r = xs();
      if (r[0]) rd(b + 21'(r[3:1]));
      else wr(b + 21'(r[3:1]), r[5:4], r[31:14]);
    end
    idle(2);
    $display("test random mix done");
    for (int o = 0; o < 2; o++) begin
      i_host.burst_order_select_n = o[0];
      idle(6);
      wr(b + 21'h2, 2'h0, 18'(xs()));
      for (int k = 0; k < 6; k++) begin
        r = xs();
        i_host.op(1'h0, r[0], r[3:1], r[20:0], 2'h0, r[31:14], k == 2);
      end
      rd(b + 21'h1);
      for (int k = 0; k < 6; k++) begin
        r = xs();
        i_host.op(1'h0, r[0], r[3:1], r[20:0], r[5:4], 18'h0, k == 3);
      end
      idle(2);
      $display("test burst order %0d done", o);
    end
    foreach (cs_bad[p]) begin
      r = xs();
      i_host.op(1'h1, 1'h0, cs_bad[p], b, 2'h0, r[17:0]);
      i_host.op(1'h1, 1'h1, cs_bad[p], b, 2'h3, 18'h0);
      rd(b);
      idle(1);
    end
    $display("test deselect done");
    i_host.output_enable_n = 1'h1;
    idle(6);
    rd(b);
    idle(1);
    i_host.output_enable_n = 1'h0;
    idle(6);
    $display("test output enable done");
    i_host.sleep_request = 1'h1;
    idle(5);
    check(18'(sleep_active), 18'h1);
    wr(b, 2'h0, 18'(xs()));
    idle(2);
    i_host.sleep_request = 1'h0;
    idle(6);
    check(18'(sleep_active), 18'h0);
    rd(b);
    idle(2);
    $display("test sleep done");
    check(18'(i_host.exp_q.size()), 18'h0);
    report_and_stop();
  end
endmodule

bind lfs_sram lfs_sram_assertions i_chk (.ref_clk, .sys_rst, .clock_hold_n,
  .chip_select_low_active, .chip_select_high_active, .chip_select_third,
  .advance_or_load, .read_not_write, .output_enable_n, .sleep_request,
  .dq_out, .dq_oe, .sleep_active);
